/* File: rtl/ffe_map.svh */
/*
  Register map and reset values of the forced check override block.
  Assumes an APB slave with 32-bit data, registers on aligned words.
*/
// How it works
// - bypass set means forced parity and check code go to flash in code or data mode; idle mode passes generated bits.
// - field meaning follows code or data flash program/erase mode.
// - bits 15..11 read as ones; software writes ones there.
// - code flash: bit 10 forced parity, bits 9..0 forced check code.
// - data flash: bits 10..7 read as ones, bits 6..0 check code.
// - forced check register is accessed with 16-bit accesses only.
// - bypass 1 disables parity generator and encoder, 0 enables both.
`ifndef FFE_MAP_SVH
`define FFE_MAP_SVH
`define FFE_TEST_MODE_OFS 12'h104
`define FFE_FORCED_OFS 12'h108
`define FFE_FORCED_RST 16'hFFFF
`define FFE_TEST_MODE_RST 16'h0030
`define FFE_TEST_MODE_WMASK 16'h0031
`define FFE_RSVD_ONES 16'hF800
`define FFE_DATA_RSVD_ONES 16'hFF80
`define FFE_BYPASS_BIT 0
`define FFE_PARITY_BIT 10
`endif

/* File: rtl/ffe_override.sv */
/*
  Forced check value register with test mode bypass, selecting forced or
  generated parity and check bits for the flash write path.
  Assumes an APB master on core_clk and the encoder output on the same clock.
*/
`timescale 1ns/1ps
`include "ffe_map.svh"
module ffe_override
  import ffe_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // flash write path
  input wire ffe_mode_t progMode,
  input wire ffe_ecc_t genEcc,
  output ffe_ecc_t flashEcc,
  output logic encoderBypass
);
  // -------------------------------------------------------------
  // register state
  // -------------------------------------------------------------
  logic [15:0] forcedReg, forcedNext;
  logic [15:0] testReg, testNext;
  logic [31:0] rdReg, rdNext;
  logic errReg, errNext;
  logic readyReg, readyNext;
  ffe_ecc_t outReg, outNext;
  logic bypReg, bypNext;
  logic setup, hit16, mapped, access;
  logic [15:0] rdForced;

  assign setup = psel && !penable;
  // halfword lanes only: writes need strobe 0011 on the low half; reads take any strobe
  assign hit16 = (pstrb == 4'h3) || !pwrite;
  assign mapped = (paddr == `FFE_FORCED_OFS) || (paddr == `FFE_TEST_MODE_OFS);
  // write lands at the access edge where pready is sampled high
  assign access = psel && penable && pwrite && readyReg && !errReg;

  // -------------------------------------------------------------
  // bus and register next values
  // -------------------------------------------------------------
  always_comb begin
    forcedNext = forcedReg;
    testNext = testReg;
    rdNext = rdReg;
    errNext = 1'b0;
    readyNext = 1'b0;
    rdForced = forcedReg | `FFE_RSVD_ONES;
    if (progMode == FFE_MODE_DATA) begin
      rdForced = forcedReg | `FFE_DATA_RSVD_ONES;
    end
    if (setup) begin
      readyNext = 1'b1;
      rdNext = 32'h0000_0000;
      if (!mapped || !hit16) begin
        errNext = 1'b1;
      end else if (pwrite) begin
        rdNext = 32'h0000_0000;
      end else if (paddr == `FFE_FORCED_OFS) begin
        rdNext = {16'h0000, rdForced};
      end else begin
        rdNext = {16'h0000, testReg};
      end
    end
    if (access) begin
      if (paddr == `FFE_FORCED_OFS) begin
        forcedNext = pwdata[15:0] | `FFE_RSVD_ONES;
      end else begin
        testNext = pwdata[15:0] & `FFE_TEST_MODE_WMASK;
      end
    end
  end

  // -------------------------------------------------------------
  // flash path selection
  // -------------------------------------------------------------
  always_comb begin
    bypNext = testNext[`FFE_BYPASS_BIT];
    outNext = genEcc;
    if (bypReg) begin
      if (progMode == FFE_MODE_CODE) begin
        outNext.parity = forcedReg[`FFE_PARITY_BIT];
        outNext.check = forcedReg[9:0];
      end else if (progMode == FFE_MODE_DATA) begin
        outNext.parity = 1'b1;
        outNext.check = {3'h7, forcedReg[6:0]};
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      forcedReg <= `FFE_FORCED_RST;
      testReg <= `FFE_TEST_MODE_RST;
      rdReg <= 32'h0000_0000;
      errReg <= 1'b0;
      readyReg <= 1'b0;
      outReg <= '0;
      bypReg <= 1'b0;
    end else begin
      forcedReg <= forcedNext;
      testReg <= testNext;
      rdReg <= rdNext;
      errReg <= errNext;
      readyReg <= readyNext;
      outReg <= outNext;
      bypReg <= bypNext;
    end
  end

  assign prdata = rdReg;
  assign pready = readyReg;
  assign pslverr = errReg;
  assign flashEcc = outReg;
  assign encoderBypass = bypReg;
endmodule

/* File: rtl/ffe_pkg.sv */
/*
  Types of the forced check override block.
  Assumes nothing beyond the map header.
*/
package ffe_pkg;
  typedef enum logic [1:0] {
    FFE_MODE_IDLE = 2'h0,
    FFE_MODE_CODE = 2'h1,
    FFE_MODE_DATA = 2'h3
  } ffe_mode_t;
  typedef struct packed {
    logic parity;
    logic [9:0] check;
  } ffe_ecc_t;
endpackage

/* File: testbench/ffe_flash_model.sv */
/* encoder stand-in on the flash write path
   assumes seed driven by the bench */
`timescale 1ns/1ps
module ffe_flash_model import ffe_pkg::*; (
  // encoder
  input wire logic core_clk,
  input wire logic [10:0] seed,
  output ffe_ecc_t genEcc);
  always_ff @(posedge core_clk) genEcc <= seed ^ 11'h2A5;
endmodule

/* File: testbench/ffe_override_monitor.sv */
/* port checker of ffe_override
   assumes bind by name */
`timescale 1ns/1ps
module ffe_chk_monitor import ffe_pkg::*; (
  // bus
  input wire logic core_clk, sys_rst, psel, penable, pwrite, pready, pslverr,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata, pwdata,
  input wire logic [3:0] pstrb,
  // flash
  input wire ffe_mode_t progMode,
  input wire ffe_ecc_t genEcc, flashEcc,
  input wire logic encoderBypass);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  AST_RDY: assert property (psel && !penable |=> pready) else $error("rdy");
  AST_ONE: assert property (pready |=> !pready) else $error("rdy2");
  AST_STB: assert property (psel && !penable && pwrite && pstrb != 4'h3 |=> pslverr)
    else $error("stb");
  AST_RSV: assert property (pready && !pwrite && paddr == 12'h108 |-> &prdata[15:11])
    else $error("rsv");
  AST_DRSV: assert property (pready && !pwrite && paddr == 12'h108 &&
    progMode == FFE_MODE_DATA |-> &prdata[15:7]) else $error("drsv");
  AST_GEN: assert property (!$past(sys_rst) && !$past(encoderBypass) |->
    flashEcc == $past(genEcc)) else $error("gen");
  AST_DBY: assert property (!$past(sys_rst) && $past(encoderBypass) &&
    $past(progMode) == FFE_MODE_DATA |-> &flashEcc[10:7]) else $error("dby");
  AST_CBY: assert property ((encoderBypass && !psel &&
    progMode == FFE_MODE_CODE)[*2] |=> $stable(flashEcc)) else $error("cby");
  AST_BYP: assert property (pready && pwrite && !pslverr && paddr == 12'h104 |=>
    encoderBypass == $past(pwdata[0])) else $error("byp");
endmodule
bind ffe_override ffe_chk_monitor ffe_chk_monitor_inst (.*);

/* File: testbench/tb_flash_forced_ecc_override.sv */
/* bench of ffe_override
   assumes model and checker compiled first */
`timescale 1ns/1ps
module tb_flash_forced_ecc_override import ffe_pkg::*;;
  logic core_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic encoderBypass, err;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [3:0] pstrb = 4'h0;
  logic [15:0] rd;
  logic [10:0] seed = 11'h0;
  logic [40:0] r;
  ffe_mode_t progMode = FFE_MODE_IDLE;
  ffe_ecc_t genEcc, flashEcc;
  int errors = 0, comparisons = 0;
  logic [40:0] rows [5] = '{{2'h1, 1'h0, 16'hF955, 11'h00F, 11'h2AA},
    {2'h1, 1'h1, 16'hF955, 11'h00F, 11'h155}, {2'h3, 1'h1, 16'hFF92, 11'h00F, 11'h792},
    {2'h3, 1'h0, 16'hFF92, 11'h7FF, 11'h55A}, {2'h0, 1'h1, 16'hF955, 11'h00F, 11'h2AA}};
  ffe_override ffe_override_inst (.*);
  ffe_flash_model ffe_flash_model_inst (.*);
  initial forever #20 core_clk = ~core_clk;
  task chk(input logic [15:0] g, e);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  task results;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [15:0] d, input logic [3:0] s);
    int n;
    @(posedge core_clk);
    {psel, pwrite, paddr, pwdata, pstrb} <= {1'b1, w, a, 16'h0, d, s};
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do @(posedge core_clk); while (pready !== 1'b1 && ++n < 9);
    rd = prdata[15:0];
    err = pslverr;
    {psel, penable} <= 2'h0;
    if (n == 9) begin
      chk(16'h0, 16'h1);
      results;
    end
  endtask
  initial begin
    repeat (12) @(posedge core_clk);
    sys_rst <= 1'b0;
    apb(1'b0, 12'h108, 16'h0, 4'h0);
    chk(rd, 16'hFFFF);
    apb(1'b0, 12'h104, 16'h0, 4'h0);
    chk(rd, 16'h0030);
    foreach (rows[i]) begin
      r = rows[i];
      apb(1'b1, 12'h104, {15'h0018, r[38]}, 4'h3);
      apb(1'b1, 12'h108, r[37:22], 4'h3);
      progMode <= ffe_mode_t'(r[40:39]);
      seed <= r[21:11];
      apb(1'b0, 12'h108, 16'h0, 4'h0);
      chk(rd, r[37:22]);
      chk({5'h0, flashEcc}, {5'h0, r[10:0]});
      $display("row %0d done", i);
    end
    apb(1'b1, 12'h108, 16'hF800, 4'hF);
    chk({15'h0, err}, 16'h1);
    apb(1'b0, 12'h1FC, 16'h0, 4'h0);
    chk({15'h0, err}, 16'h1);
    apb(1'b0, 12'h108, 16'h0, 4'h0);
    chk(rd, 16'hF955);
    $display("refusal tests done");
    results;
  end
endmodule
